// *** hdl/rctc_regs.sv ***
// clock, trim and power configuration registers of the radio
// assumes the serial port delivers one-cycle write and read strobes with
// address and data synchronous to i_clk; the analog control write-enable
// bit arrives as a level from its own register outside this bank
`timescale 1ns/1ps
`default_nettype none
`include "rctc_map.svh"

module rctc_regs (
    input  wire logic                i_clk,
    input  wire logic                i_rst_n,
    input  wire logic                i_wr_stb,
    input  wire logic                i_rd_stb,
    input  wire rctc_pkg::rctc_addr_t i_addr,
    input  wire rctc_pkg::rctc_byte_t i_wdata,
    input  wire logic                i_analog_wr_en,
    input  wire logic                i_sys_clk,
    input  wire logic                i_carrier_detect,
    output logic                     o_rd_valid,
    output rctc_pkg::rctc_byte_t     o_rdata,
    output logic                     o_system_clock_out_pin,
    output logic                     o_system_clock_out_pin_oe,
    output logic [5:0]               o_xtal_trim,
    output rctc_pkg::rctc_slope_e    o_osc_slope,
    output logic                     o_pwr_save,
    output logic                     o_carrier_detect,
    output rctc_pkg::rctc_byte_t     o_clk_override,
    output rctc_pkg::rctc_byte_t     o_clk_gating
);

    rctc_pkg::rctc_byte_t  trim_reg;
    rctc_pkg::rctc_byte_t  trim_next;
    rctc_pkg::rctc_slope_e slope_reg;
    rctc_pkg::rctc_slope_e slope_next;
    rctc_pkg::rctc_byte_t  pwr_reg;
    rctc_pkg::rctc_byte_t  pwr_next;
    rctc_pkg::rctc_byte_t  cso_reg;
    rctc_pkg::rctc_byte_t  cso_next;
    rctc_pkg::rctc_byte_t  ovr_reg;
    rctc_pkg::rctc_byte_t  ovr_next;
    rctc_pkg::rctc_byte_t  gat_reg;
    rctc_pkg::rctc_byte_t  gat_next;
    rctc_pkg::rctc_byte_t  rdata_reg;
    rctc_pkg::rctc_byte_t  rdata_next;
    logic                  rdv_reg;
    logic                  rdv_next;
    logic                  clko_reg;
    logic                  clko_next;
    logic                  clkoe_reg;
    logic                  clkoe_next;
    logic                  cd_reg;
    logic                  cd_next;

    function automatic logic hit(input rctc_pkg::rctc_addr_t a,
                                 input rctc_pkg::rctc_addr_t ofs);
        hit = (a == ofs);
    endfunction : hit

    function automatic logic wr_hit(input logic                 stb,
                                    input rctc_pkg::rctc_addr_t a,
                                    input rctc_pkg::rctc_addr_t ofs);
        wr_hit = stb & hit(a, ofs);
    endfunction : wr_hit

    // gated registers also need the analog write enable
    function automatic logic gated_hit(input logic                 stb,
                                       input logic                 en,
                                       input rctc_pkg::rctc_addr_t a,
                                       input rctc_pkg::rctc_addr_t ofs);
        gated_hit = wr_hit(stb, a, ofs) & en;
    endfunction : gated_hit

    // slope is write-only; reading back zero keeps the bus defined
    function automatic rctc_pkg::rctc_byte_t read_mux(input rctc_pkg::rctc_addr_t a);
        case (a)
            `RCTC_OFS_XTAL_TRIM:    read_mux = trim_reg;
            `RCTC_OFS_OSC_SLOPE:    read_mux = `RCTC_RESET_VALUE;
            `RCTC_OFS_PWR_SAVE:     read_mux = pwr_reg;
            `RCTC_OFS_CS_OVERRIDE:  read_mux = cso_reg;
            `RCTC_OFS_CLK_OVERRIDE: read_mux = ovr_reg;
            `RCTC_OFS_CLK_GATING:   read_mux = gat_reg;
            default:                read_mux = `RCTC_RESET_VALUE;
        endcase
    endfunction : read_mux

    // stored whole; reserved bit 7 is the host's to keep at zero
    always_comb begin
        trim_next = trim_reg;
        if (wr_hit(i_wr_stb, i_addr, `RCTC_OFS_XTAL_TRIM)) begin
            trim_next = i_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            trim_reg <= `RCTC_RESET_VALUE;
        end else begin
            trim_reg <= trim_next;
        end
    end

    always_comb begin
        slope_next = slope_reg;
        if (wr_hit(i_wr_stb, i_addr, `RCTC_OFS_OSC_SLOPE)) begin
            slope_next = rctc_pkg::rctc_slope_e'(
                i_wdata[`RCTC_SLOPE_MSB:`RCTC_SLOPE_LSB]);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            slope_reg <= rctc_pkg::rctc_slope_none;
        end else begin
            slope_reg <= slope_next;
        end
    end

    // ignored without the analog write enable, keeping old contents
    always_comb begin
        pwr_next = pwr_reg;
        if (gated_hit(i_wr_stb, i_analog_wr_en, i_addr, `RCTC_OFS_PWR_SAVE)) begin
            pwr_next = i_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pwr_reg <= `RCTC_RESET_VALUE;
        end else begin
            pwr_reg <= pwr_next;
        end
    end

    always_comb begin
        cso_next = cso_reg;
        if (gated_hit(i_wr_stb, i_analog_wr_en, i_addr, `RCTC_OFS_CS_OVERRIDE)) begin
            cso_next = i_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cso_reg <= `RCTC_RESET_VALUE;
        end else begin
            cso_reg <= cso_next;
        end
    end

    always_comb begin
        ovr_next = ovr_reg;
        if (wr_hit(i_wr_stb, i_addr, `RCTC_OFS_CLK_OVERRIDE)) begin
            ovr_next = i_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ovr_reg <= `RCTC_RESET_VALUE;
        end else begin
            ovr_reg <= ovr_next;
        end
    end

    always_comb begin
        gat_next = gat_reg;
        if (wr_hit(i_wr_stb, i_addr, `RCTC_OFS_CLK_GATING)) begin
            gat_next = i_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gat_reg <= `RCTC_RESET_VALUE;
        end else begin
            gat_reg <= gat_next;
        end
    end

    // write and read in one cycle: the read returns the old value
    always_comb begin
        rdata_next = rdata_reg;
        if (i_rd_stb) begin
            rdata_next = read_mux(i_addr);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_reg <= `RCTC_RESET_VALUE;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    always_comb begin
        rdv_next = i_rd_stb;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdv_reg <= 1'b0;
        end else begin
            rdv_reg <= rdv_next;
        end
    end

    // gate follows the trim write at once, so enable and register move together
    always_comb begin
        clkoe_next = ~trim_next[`RCTC_BIT_CLK_OUT_OFF];
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            clkoe_reg <= 1'b0;
        end else begin
            clkoe_reg <= clkoe_next;
        end
    end

    // clock is registered, so the pin lags i_sys_clk by one cycle
    always_comb begin
        clko_next = ~trim_next[`RCTC_BIT_CLK_OUT_OFF] & i_sys_clk;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            clko_reg <= 1'b0;
        end else begin
            clko_reg <= clko_next;
        end
    end

    // override forces the indication high whatever the detector says
    always_comb begin
        cd_next = cso_next[`RCTC_BIT_CS_OVERRIDE] | i_carrier_detect;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cd_reg <= 1'b0;
        end else begin
            cd_reg <= cd_next;
        end
    end

    assign o_rd_valid                = rdv_reg;
    assign o_rdata                   = rdata_reg;
    assign o_system_clock_out_pin    = clko_reg;
    assign o_system_clock_out_pin_oe = clkoe_reg;
    assign o_xtal_trim               = trim_reg[`RCTC_TRIM_MSB:0];
    assign o_osc_slope               = slope_reg;
    assign o_pwr_save                = pwr_reg[`RCTC_BIT_PWR_SAVE];
    assign o_carrier_detect          = cd_reg;
    assign o_clk_override            = ovr_reg;
    assign o_clk_gating              = gat_reg;

endmodule : rctc_regs
`default_nettype wire

// *** include/rctc_map.svh ***
// register offsets, field positions and reset values of the clock and trim bank
// assumes 8-bit registers on a 6-bit register address
`ifndef RCTC_MAP_SVH
`define RCTC_MAP_SVH
`define RCTC_OFS_XTAL_TRIM    6'h24
`define RCTC_OFS_OSC_SLOPE    6'h25
`define RCTC_OFS_PWR_SAVE     6'h2e
`define RCTC_OFS_CS_OVERRIDE  6'h2f
`define RCTC_OFS_CLK_OVERRIDE 6'h32
`define RCTC_OFS_CLK_GATING   6'h33
`define RCTC_BIT_CLK_OUT_OFF  6
`define RCTC_TRIM_MSB         5
`define RCTC_SLOPE_MSB        7
`define RCTC_SLOPE_LSB        6
`define RCTC_BIT_PWR_SAVE     7
`define RCTC_BIT_CS_OVERRIDE  7
`define RCTC_RESET_VALUE      8'h00
`endif

// *** include/rctc_pkg.sv ***
// types shared by the clock and trim register bank
// assumes the offsets live in rctc_map.svh
package rctc_pkg;
    typedef logic [7:0] rctc_byte_t;
    typedef logic [5:0] rctc_addr_t;
    typedef enum logic [1:0] {
        rctc_slope_none = 2'h0,
        rctc_slope_rsvd = 2'h1,
        rctc_slope_2_3  = 2'h2,
        rctc_slope_5_5  = 2'h3
    } rctc_slope_e;
endpackage : rctc_pkg

// *** testbench/rctc_host.sv ***
// host model on the register port of the bank
// assumes tasks are called just after a rising edge of i_clk
`timescale 1ns/1ps
`default_nettype none
module rctc_host (
    input  wire logic            i_clk,
    input  wire rctc_pkg::rctc_byte_t i_rdata,
    output logic                 o_wr, o_rd, o_en,
    output rctc_pkg::rctc_addr_t o_addr,
    output rctc_pkg::rctc_byte_t o_wdata
);
    initial {o_wr, o_rd, o_en, o_addr, o_wdata} = 17'h0;
    task wr(input rctc_pkg::rctc_addr_t a, input rctc_pkg::rctc_byte_t d);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk) o_wr <= 1'b0;
        o_wdata <= ~d;
        @(posedge i_clk);
    endtask : wr
    task rd(input rctc_pkg::rctc_addr_t a, output rctc_pkg::rctc_byte_t d);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk) o_rd <= 1'b0;
        @(posedge i_clk) d = i_rdata;
    endtask : rd
    // clock out left off: it spoils every 13th channel
    task init();
        o_en <= 1'b1;
        @(posedge i_clk);
        wr(6'h25, 8'hc0);
        wr(6'h2e, 8'h80);
        wr(6'h32, 8'h41);
        wr(6'h33, 8'h41);
        wr(6'h24, 8'h40);
    endtask : init
endmodule : rctc_host
`default_nettype wire

// *** testbench/rctc_regs_assertions.sv ***
// checker for the clock and trim bank
// assumes a bind onto rctc_regs
`timescale 1ns/1ps
`default_nettype none
module rctc_regs_assertions (
    input wire logic i_clk, i_rst_n, i_wr_stb, i_rd_stb, i_analog_wr_en, o_rd_valid,
    input wire logic o_system_clock_out_pin, o_system_clock_out_pin_oe, o_pwr_save,
    input wire logic o_carrier_detect,
    input wire rctc_pkg::rctc_addr_t i_addr,
    input wire rctc_pkg::rctc_byte_t i_wdata,
    input wire logic [5:0] o_xtal_trim,
    input wire rctc_pkg::rctc_slope_e o_osc_slope
);
    // address zero is unmapped, so it stands for no write
    wire logic [5:0] a = i_wr_stb ? i_addr : 6'h00;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    AST_RD: assert property (i_rd_stb |=> o_rd_valid) else $error("read valid late");
    AST_OE: assert property (a == 6'h24 |=> o_system_clock_out_pin_oe != $past(i_wdata[6]))
        else $error("clock enable wrong");
    AST_OFF: assert property (!o_system_clock_out_pin_oe && !$past(o_system_clock_out_pin_oe)
        |-> !o_system_clock_out_pin) else $error("clock pin driven");
    AST_TRIM: assert property (a == 6'h24 |=> o_xtal_trim == $past(i_wdata[5:0]))
        else $error("trim wrong");
    AST_SLOPE: assert property (a == 6'h25 |=> o_osc_slope == $past(i_wdata[7:6]))
        else $error("slope wrong");
    AST_PWR: assert property (a == 6'h2e && i_analog_wr_en |=> o_pwr_save == $past(i_wdata[7]))
        else $error("power save wrong");
    AST_GATE: assert property (a == 6'h2e && !i_analog_wr_en |=> $stable(o_pwr_save))
        else $error("gated write taken");
    AST_CS: assert property (a == 6'h2f && i_analog_wr_en && i_wdata[7] |=> o_carrier_detect)
        else $error("override lost");
endmodule : rctc_regs_assertions
bind rctc_regs rctc_regs_assertions chk_u (.*);
`default_nettype wire

// *** testbench/rctc_regs_bench.sv ***
// self-checking bench for the clock and trim bank
// assumes rctc_host drives the register port
`timescale 1ns/1ps
`default_nettype none
module rctc_regs_bench;
    typedef struct {rctc_pkg::rctc_addr_t a; rctc_pkg::rctc_byte_t d, e;} rctc_row_s;
    logic i_clk = 1'b0, i_rst_n = 1'b0, i_sys_clk = 1'b0, i_carrier_detect = 1'b0;
    logic i_wr_stb, i_rd_stb, i_analog_wr_en, o_rd_valid, o_pwr_save, o_carrier_detect;
    logic o_system_clock_out_pin, o_system_clock_out_pin_oe;
    logic [5:0] o_xtal_trim;
    rctc_pkg::rctc_addr_t i_addr;
    rctc_pkg::rctc_byte_t i_wdata, o_rdata, o_clk_override, o_clk_gating, got;
    rctc_pkg::rctc_slope_e o_osc_slope;
    int err_count = 0, comparisons = 0, cyc = 0;
    // 0x10 is unmapped; 0x2e last so the gated write below starts from zero
    rctc_row_s rows [5] = '{'{6'h24, 8'h15, 8'h15}, '{6'h2f, 8'h80, 8'h80},
        '{6'h33, 8'h41, 8'h41}, '{6'h10, 8'h55, 8'h00}, '{6'h2e, 8'h00, 8'h00}};
    rctc_regs dut_u (.*);
    rctc_host host_u (.i_clk(i_clk), .i_rdata(o_rdata), .o_wr(i_wr_stb), .o_rd(i_rd_stb),
        .o_en(i_analog_wr_en), .o_addr(i_addr), .o_wdata(i_wdata));
    always #25 i_clk = ~i_clk;
    task close_out();
        if (err_count == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out
    task chk(input string n, input rctc_pkg::rctc_byte_t s, input rctc_pkg::rctc_byte_t e);
        comparisons++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask : chk
    always @(posedge i_clk) begin
        i_sys_clk <= ~i_sys_clk;
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_count++;
            close_out();
        end
    end
    initial begin
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        host_u.init();
        chk("gating", o_clk_gating, 8'h41);
        chk("pwr", {7'h0, o_pwr_save}, 8'h01);
        chk("oe", {7'h0, o_system_clock_out_pin_oe}, 8'h00);
        chk("override", o_clk_override, 8'h41);
        @(negedge i_clk);
        chk("pin off", {7'h0, o_system_clock_out_pin}, 8'h00);
        @(posedge i_clk);
        foreach (rows[i]) begin
            host_u.wr(rows[i].a, rows[i].d);
            host_u.rd(rows[i].a, got);
            chk("row", got, rows[i].e);
        end
        chk("trim", {2'h0, o_xtal_trim}, 8'h15);
        chk("cd", {7'h0, o_carrier_detect}, 8'h01);
        chk("oe", {7'h0, o_system_clock_out_pin_oe}, 8'h01);
        @(negedge i_clk);
        chk("pin", {7'h0, o_system_clock_out_pin}, {7'h0, ~i_sys_clk});
        @(posedge i_clk);
        host_u.o_en <= 1'b0;
        host_u.wr(6'h2e, 8'h80);
        host_u.rd(6'h2e, got);
        chk("gated", got, 8'h00);
        for (int k = 0; k < 4; k++) begin
            host_u.wr(6'h25, 8'(k << 6));
            chk("slope", {6'h0, o_osc_slope}, 8'(k));
        end
        i_rst_n <= 1'b0;
        @(posedge i_clk) i_rst_n <= 1'b1;
        foreach (rows[i]) begin
            host_u.rd(rows[i].a, got);
            chk("reset", got, 8'h00);
        end
        chk("cd idle", {7'h0, o_carrier_detect}, 8'h00);
        i_carrier_detect <= 1'b1;
        repeat (2) @(posedge i_clk);
        chk("cd live", {7'h0, o_carrier_detect}, 8'h01);
        close_out();
    end
endmodule : rctc_regs_bench
`default_nettype wire
